// ---- hdl/sadl_core.sv ----
// module: squib arming, deploy timing, diagnostics and register port
`timescale 1ns/1ns
module sadl_core
  import sadl_pkg::*;
#(
  parameter int FIRE_CYCLES    = FIRE_CYC,
  parameter int STRETCH_CYCLES = STRETCH_CYC,
  parameter int DIAG_CYCLES    = DIAG_CYC
)(
  input  wire logic              clk_in,
  input  wire logic              reset_n_in,
  input  wire logic              deploy_permit_in,
  input  wire logic [NCH-1:0]    ground_ok_in,
  input  wire logic [NCH-1:0]    loop_volt_in,
  input  wire logic [NCH-1:0]    loop_curr_in,
  input  wire logic              arm_sclk_in,
  input  wire logic              arm_sel_n_in,
  input  wire logic              arm_mosi_in,
  output logic                   arm_miso_out,
  input  wire logic              dep_sclk_in,
  input  wire logic              dep_sel_n_in,
  input  wire logic              dep_mosi_in,
  output logic                   dep_miso_out,
  input  wire logic [REG_AW-1:0] reg_addr_in,
  input  wire logic [31:0]       reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [31:0]       reg_rdata_out,
  output logic                   irq_out,
  output logic      [NCH-1:0]    high_side_fire_out,
  output logic      [NCH-1:0]    low_side_fire_out
);

  function automatic logic rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  function automatic logic [NCH-1:0] ch_dec(input logic [CH_W-1:0] ch);
    return NCH'(1) << ch;
  endfunction

  logic [PIN_W-1:0] pin_raw, s1_q, s2_q, s3_q;
  logic [1:0]       rst_s_q;
  logic             rst_pend_q, rst_any, any_fire, soft_rst, permit_s;
  logic [NCH-1:0]   gnd_s, arm_hit, dep_hit, trig, trun, done_ev;
  logic [NCH-1:0]   tsrc_q, fire_q, succ_q, hs_q, ls_q, dres_q, d_sel;
  logic [CNT_W-1:0] tmr_q [NCH];
  logic [CNT_W-1:0] fcnt_q [NCH];
  logic [1:0]       cmd_v, ferr;
  logic [7:0]       cmd_b [2];
  logic [1:0]       miso_b;
  sadl_op_t         op, dop_q;
  logic [CH_W-1:0]  dch_q;
  sadl_diag_t       dst_q;
  logic [CNT_W-1:0] dcnt_q;
  logic             diag_go, dfault, d_hs, d_ls, ddone_ev;
  logic [ST_W-1:0]  status_q, mask_q, ev, clr;
  logic [31:0]      rd_mux, rdata_q;
  logic             irq_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  //--------------------------------------------------------------
  // pin synchronisers and reset hold-off
  //--------------------------------------------------------------
  assign pin_raw = {loop_curr_in, loop_volt_in, ground_ok_in, deploy_permit_in,
                    dep_mosi_in, dep_sel_n_in, dep_sclk_in,
                    arm_mosi_in, arm_sel_n_in, arm_sclk_in};
  assign permit_s = s2_q[P_PERMIT];
  assign gnd_s    = s2_q[P_GND +: NCH];

  // third stage only keeps the previous value for edge finding
  always_ff @(posedge clk_in)
  begin
    s1_q <= pin_raw;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      rst_s_q <= 2'b00;
    else
      rst_s_q <= {rst_s_q[0], 1'b1};
  end

  // reset is remembered while any channel fires and applied after
  assign any_fire = |fire_q;
  assign rst_any  = ~rst_s_q[1] | rst_pend_q;
  assign soft_rst = rst_any & ~any_fire;  // see RULE19

  always_ff @(posedge clk_in)
    rst_pend_q <= ~rst_s_q[1] | (rst_pend_q & any_fire);  // see RULE19

  //--------------------------------------------------------------
  // serial ports: 0 arming, 1 deploy and diagnostic
  //--------------------------------------------------------------
  for (genvar p = 0; p < 2; p++)
  begin : g_port
    localparam int B = P_ASCLK + 3 * p;
    logic [7:0]        sh_q, cmd_q, pre;
    logic [BCNT_W-1:0] bc_q;
    logic              miso_q, cmd_v_q, ferr_q, sel, st, en, sr, sf;
    assign sel = ~s2_q[B+1];
    assign st  = rise(s3_q[B+1], s2_q[B+1]);
    assign en  = rise(s2_q[B+1], s3_q[B+1]);
    assign sr  = sel & rise(s2_q[B], s3_q[B]);
    assign sf  = sel & rise(s3_q[B], s2_q[B]);
    // arming port keeps old data so it flows on down a chain
    assign pre = (p == 1) ? succ_q : sh_q;  // see RULE7, see RULE12

    // frames of whole bytes only; last byte in the chain is taken
    always_ff @(posedge clk_in)
    begin
      if (soft_rst)
      begin
        sh_q    <= 8'h00;
        cmd_q   <= 8'h00;
        bc_q    <= '0;
        miso_q  <= 1'b0;
        cmd_v_q <= 1'b0;
        ferr_q  <= 1'b0;
      end
      else
      begin
        cmd_v_q <= en & (bc_q != '0) & (bc_q[2:0] == 3'h0);  // see RULE4
        ferr_q  <= en & ((bc_q == '0) | (bc_q[2:0] != 3'h0));
        if (en)
          cmd_q <= sh_q;
        if (st)
        begin
          bc_q   <= '0;
          sh_q   <= pre;
          miso_q <= pre[7];
        end
        else
        begin
          if (sr)
          begin
            sh_q <= {sh_q[6:0], s2_q[B+2]};  // see RULE7
            bc_q <= bc_q + 1'b1;
          end
          if (sf)
            miso_q <= sh_q[7];
        end
      end
    end
    assign cmd_v[p]  = cmd_v_q;
    assign ferr[p]   = ferr_q;
    assign cmd_b[p]  = cmd_q;
    assign miso_b[p] = miso_q;
  end
  assign arm_miso_out = miso_b[0];
  assign dep_miso_out = miso_b[1];
  assign op = sadl_op_t'(cmd_b[1][CMD_W-1:OP_LSB]);

  //--------------------------------------------------------------
  // per-channel stretch timer and firing
  //--------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    assign arm_hit[c] = cmd_v[0] & cmd_b[0][c];
    assign dep_hit[c] = cmd_v[1] & (op == OP_DEPLOY) & (cmd_b[1][CH_W-1:0] == CH_W'(c));
    assign trun[c]    = tmr_q[c] != '0;
    // both commands in one cycle count as a completed pair
    assign trig[c] = permit_s & gnd_s[c] & ~rst_any & ~fire_q[c]  // see RULE3, see RULE16
                   & ((arm_hit[c] & dep_hit[c])
                   | (trun[c] & tsrc_q[c] & dep_hit[c])
                   | (trun[c] & ~tsrc_q[c] & arm_hit[c]));
    assign done_ev[c] = fire_q[c] & (fcnt_q[c] == CNT_W'(FIRE_CYCLES - 1));

    // count down; zero means unarmed, a repeat of the same command is ignored
    always_ff @(posedge clk_in)
    begin
      if (soft_rst)
      begin
        tmr_q[c]  <= '0;
        tsrc_q[c] <= 1'b0;
      end
      else if (trig[c])
        tmr_q[c] <= '0;
      else if (trun[c])
        tmr_q[c] <= tmr_q[c] - 1'b1;  // see RULE18
      else if (arm_hit[c] | dep_hit[c])
      begin
        tmr_q[c]  <= CNT_W'(STRETCH_CYCLES);  // see RULE1, see RULE2
        tsrc_q[c] <= arm_hit[c];
      end
    end

    // no reset here: a firing channel ignores reset until done
    always_ff @(posedge clk_in)
    begin
      if (fire_q[c])
      begin
        if (done_ev[c])
          fire_q[c] <= 1'b0;  // see RULE6, see RULE14
        fcnt_q[c] <= fcnt_q[c] + 1'b1;
      end
      else
      begin
        fire_q[c] <= trig[c];  // see RULE15
        fcnt_q[c] <= '0;
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (soft_rst)
      succ_q <= '0;
    else
      succ_q <= succ_q | done_ev;  // see RULE12
  end

  //--------------------------------------------------------------
  // driver diagnostics
  //--------------------------------------------------------------
  assign diag_go  = cmd_v[1] & (op >= OP_BAT) & (op <= OP_MOS)  // see RULE10
                  & (dst_q == D_IDLE) & ~any_fire;
  assign d_sel    = ch_dec(dch_q);
  assign d_hs     = (dst_q == D_RUN) & (dop_q == OP_RES);
  assign d_ls     = (dst_q == D_RUN) & (dop_q == OP_MOS);
  assign ddone_ev = dst_q == D_SAMP;

  // a floating low-side source carries no current and fails the test
  always_comb
  begin
    unique case (dop_q)
      OP_BAT:  dfault = s2_q[P_VOLT + dch_q];
      OP_GND:  dfault = s2_q[P_CURR + dch_q];
      OP_RES:  dfault = ~s2_q[P_CURR + dch_q];
      OP_MOS:  dfault = ~s2_q[P_CURR + dch_q] | ~gnd_s[dch_q];  // see RULE17
      default: dfault = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (soft_rst)
    begin
      dst_q  <= D_IDLE;
      dop_q  <= OP_NONE;
      dch_q  <= '0;
      dcnt_q <= '0;
      dres_q <= '0;
    end
    else
      unique case (dst_q)
        D_IDLE:
          if (diag_go)
          begin
            dst_q  <= D_RUN;
            dop_q  <= op;
            dch_q  <= cmd_b[1][CH_W-1:0];
            dcnt_q <= CNT_W'(DIAG_CYCLES - 1);
          end
        D_RUN:
          if (dcnt_q == '0)
            dst_q <= D_SAMP;
          else
            dcnt_q <= dcnt_q - 1'b1;
        D_SAMP:
        begin
          dst_q         <= D_IDLE;
          dres_q[dch_q] <= dfault;
        end
        default: dst_q <= D_IDLE;
      endcase
  end

  // drivers: deployment or a short diagnostic pulse, nothing else
  always_ff @(posedge clk_in)
  begin
    hs_q <= fire_q | ({NCH{d_hs}} & d_sel);  // see RULE5, see RULE13
    ls_q <= fire_q | ({NCH{d_ls}} & d_sel);  // see RULE5, see RULE13
  end
  assign high_side_fire_out = hs_q;
  assign low_side_fire_out  = ls_q;

  //--------------------------------------------------------------
  // register port and interrupt
  //--------------------------------------------------------------
  assign ev  = {|ferr, ddone_ev & dfault, ddone_ev, done_ev};
  assign clr = (reg_wr_in && reg_addr_in == ADDR_STATUS) ? reg_wdata_in[ST_W-1:0] : '0;
  assign rd_mux = (reg_addr_in == ADDR_STATUS) ? 32'(status_q)
                : (reg_addr_in == ADDR_MASK)   ? 32'(mask_q)
                : (reg_addr_in == ADDR_STATE)  ? 32'({trun, fire_q})
                : (reg_addr_in == ADDR_DIAG)   ? 32'(dres_q)
                : 32'h0000_0000;

  // a new event beats a clear in the same cycle
  always_ff @(posedge clk_in)
  begin
    if (soft_rst)
    begin
      status_q <= '0;
      mask_q   <= '0;
      rdata_q  <= 32'h0000_0000;
      irq_q    <= 1'b0;
    end
    else
    begin
      status_q <= (status_q & ~clr) | ev;
      if (reg_wr_in && reg_addr_in == ADDR_MASK)
        mask_q <= reg_wdata_in[ST_W-1:0];
      rdata_q <= reg_rd_in ? rd_mux : 32'h0000_0000;
      irq_q   <= |(status_q & mask_q);
    end
  end
  assign reg_rdata_out = rdata_q;
  assign irq_out       = irq_q;

  //--------------------------------------------------------------
  // checks
  //--------------------------------------------------------------
  logic [CNT_W-1:0] h_len_q;
  always_ff @(posedge clk_in)
    h_len_q <= fire_q[0] ? h_len_q + 1'b1 : '0;

  sequence s_fire0_start;
    !fire_q[0] ##1 fire_q[0];
  endsequence
  sequence s_arm_idle0;
    !trun[0] && arm_hit[0] && !trig[0] && !rst_any;
  endsequence

  property p_fire_gated;
    s_fire0_start |-> $past(permit_s) && $past(gnd_s[0]);
  endproperty
  a_fire_gated: assert property (p_fire_gated) else $error("fire without permit"); // see RULE3
  property p_gnd_block;
    !gnd_s[3] && !fire_q[3] |=> !fire_q[3];
  endproperty
  a_gnd_block: assert property (p_gnd_block) else $error("fired on lost ground"); // see RULE16
  property p_fire_len;
    $fell(fire_q[0]) |-> h_len_q == CNT_W'(FIRE_CYCLES);
  endproperty
  a_fire_len: assert property (p_fire_len) else $error("fire length wrong"); // see RULE14
  property p_fire_hold;
    fire_q[0] && !done_ev[0] |=> fire_q[0];
  endproperty
  a_fire_hold: assert property (p_fire_hold) else $error("fire cut short"); // see RULE6
  property p_rst_after;
    rst_any && !any_fire |=> status_q == '0 && dst_q == D_IDLE && tmr_q[0] == '0;
  endproperty
  a_rst_after: assert property (p_rst_after) else $error("held reset not applied"); // see RULE19
  property p_success;
    done_ev[0] |=> succ_q[0] && status_q[0] ##1 !fire_q[0];
  endproperty
  a_success: assert property (p_success) else $error("success flag missing"); // see RULE12
  property p_drv_off;
    hs_q[2] |-> $past(fire_q[2]) || $past(dst_q == D_RUN && dop_q == OP_RES);
  endproperty
  a_drv_off: assert property (p_drv_off) else $error("driver on without cause"); // see RULE13
  property p_expire;
    tmr_q[4] == CNT_W'(1) && !trig[4] && !rst_any |=> !trun[4];
  endproperty
  a_expire: assert property (p_expire) else $error("timer did not expire"); // see RULE18
  property p_arm_start;
    s_arm_idle0 |=> trun[0] && tsrc_q[0];
  endproperty
  a_arm_start: assert property (p_arm_start) else $error("arming did not start timer"); // see RULE2
  property p_diag_cmd;
    $rose(dst_q == D_RUN) |-> $past(cmd_v[1]) && !$past(any_fire);
  endproperty
  a_diag_cmd: assert property (p_diag_cmd) else $error("diagnostic without command"); // see RULE10

endmodule // sadl_core

// ---- pkg/sadl_pkg.sv ----
// package: constants and types of the squib arming and deploy logic
// Functional notes
// RULE1: every channel owns its own pulse stretch timer
// RULE2: arming or deploy command, whichever first, starts the channel timer
// RULE3: fire only with permit, on the complementary command inside the running timer
// RULE4: arming uses its own serial port carrying 8-bit messages
// RULE5: drivers switch on only after a valid deploy command or diagnostic
// RULE6: a started deployment runs to its end; not even reset can stop it
// RULE7: the arming port passes data through for daisy chaining
// RULE8: host chains its output through every device and back to itself
// RULE9: host selects each device on a shared bus with its own select
// RULE10: diagnostics run only on a valid serial command, four kinds
// RULE11: host keeps the permit low while diagnostics run
// RULE12: a finished deployment sets that channel's success flag, serially readable
// RULE13: drivers stay off except deployment and brief diagnostic pulses
// RULE14: a triggered channel holds its drive at least 2 ms
// RULE15: all eight channels may fire together, with no serialisation
// RULE16: lost ground blocks firing on that channel only
// RULE17: lost ground shows as a low-side diagnostic fault
// RULE18: timer length is a parameter; expiry returns the channel to unarmed
// RULE19: reset during deployment is held until it ends, then clears everything
package sadl_pkg;
  localparam int CLK_HZ      = 20_000_000;
  localparam int CLK_MHZ     = CLK_HZ / 1_000_000;
  localparam int FIRE_MIN_NS = 2_000_000;
  localparam int FIRE_CYC    = (FIRE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int STRETCH_NS  = 4_000_000;
  localparam int STRETCH_CYC = STRETCH_NS * CLK_MHZ / 1000;
  localparam int DIAG_NS     = 10_000;
  localparam int DIAG_CYC    = DIAG_NS * CLK_MHZ / 1000;
  localparam int NCH         = 8;
  localparam int CH_W        = 3;
  localparam int CNT_W       = 17;
  localparam int BCNT_W      = 6;
  localparam int CMD_W       = 8;
  localparam int OP_LSB      = 5;
  // synchronised pin vector layout
  localparam int P_ASCLK     = 0;
  localparam int P_PERMIT    = 6;
  localparam int P_GND       = 7;
  localparam int P_VOLT      = 15;
  localparam int P_CURR      = 23;
  localparam int PIN_W       = 31;
  // register map and fields
  localparam int          REG_AW      = 4;
  localparam logic [3:0]  ADDR_STATUS = 4'h0;
  localparam logic [3:0]  ADDR_MASK   = 4'h4;
  localparam logic [3:0]  ADDR_STATE  = 4'h8;
  localparam logic [3:0]  ADDR_DIAG   = 4'hc;
  localparam int          ST_W        = 11;
  localparam int          STATE_TMR   = 8;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0, OP_DEPLOY = 3'h1, OP_BAT = 3'h2, OP_GND = 3'h3,
    OP_RES = 3'h4, OP_MOS = 3'h5
  } sadl_op_t;
  typedef enum logic [1:0] {D_IDLE = 2'h0, D_RUN = 2'h1, D_SAMP = 2'h3} sadl_diag_t;
endpackage

// ---- sim/sadl_host_model.sv ----
// host serial master model for one port of the squib logic
`timescale 1ns/1ns
module sadl_host_model (
  output logic      sclk_out,
  output logic      sel_n_out,
  output logic      mosi_out,
  input  wire logic miso_in
);
  // ----------------
  // frame engine
  // ----------------
  logic [7:0] rx_q;

  // idle: own select high, clock parked low between frames
  initial
  begin
    sclk_out  = 1'b0;
    sel_n_out = 1'b1;
    mosi_out  = 1'b0;
    rx_q      = 8'h00;
  end

  // msb first, 400 ns clock; miso taken on rising clock, settled by then
  // nbits below 8 makes a cut frame, which the block must flag
  task automatic xfer(input logic [7:0] tx, input int nbits = 8);
    // keep every pin change off the block's clock edges
    #10;
    sel_n_out = 1'b0;
    #400;
    for (int i = 7; i > 7 - nbits; i--)
    begin
      mosi_out = tx[i];
      #200;
      sclk_out = 1'b1;
      rx_q     = {rx_q[6:0], miso_in};
      #200;
      sclk_out = 1'b0;
    end
    #200;
    sel_n_out = 1'b1;
    // released line must not keep showing the last bit
    mosi_out  = ~mosi_out;
    #400;
  endtask
endmodule // sadl_host_model

// ---- sim/tb_top.sv ----
// self-checking bench for the squib arming and deploy logic
`timescale 1ns/1ns
module tb_top
  import sadl_pkg::*;
;
  // ----------------
  // bench state
  // ----------------
  localparam int FIRE_C = 20;
  localparam int STR_C  = 1000;
  localparam int DIAG_C = 8;
  logic        clk, reset_n, permit, reg_wr, reg_rd, irq, cnt_clr;
  logic [7:0]  ground_ok, loop_volt, loop_curr, hi_fire, lo_fire;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic        a_sclk, a_sel_n, a_mosi, a_miso, d_sclk, d_sel_n, d_mosi, d_miso;
  logic        all_seen = 1'b0;
  int          err_total, checks, hi_cnt[8], lo_cnt[8];
  int          cyc = 0;

  sadl_core #(.FIRE_CYCLES(FIRE_C), .STRETCH_CYCLES(STR_C), .DIAG_CYCLES(DIAG_C))
  i_sadl_core (
    .clk_in(clk), .reset_n_in(reset_n), .deploy_permit_in(permit),
    .ground_ok_in(ground_ok), .loop_volt_in(loop_volt), .loop_curr_in(loop_curr),
    .arm_sclk_in(a_sclk), .arm_sel_n_in(a_sel_n), .arm_mosi_in(a_mosi),
    .arm_miso_out(a_miso), .dep_sclk_in(d_sclk), .dep_sel_n_in(d_sel_n),
    .dep_mosi_in(d_mosi), .dep_miso_out(d_miso), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .irq_out(irq), .high_side_fire_out(hi_fire),
    .low_side_fire_out(lo_fire)
  );
  sadl_host_model i_sadl_host_model_arm (.sclk_out(a_sclk), .sel_n_out(a_sel_n),
    .mosi_out(a_mosi), .miso_in(a_miso));
  sadl_host_model i_sadl_host_model_dep (.sclk_out(d_sclk), .sel_n_out(d_sel_n),
    .mosi_out(d_mosi), .miso_in(d_miso));

  // 20 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // drive-time counters per channel, plus hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      conclude();
    end
    for (int c = 0; c < 8; c++)
    begin
      hi_cnt[c] <= cnt_clr ? 0 : hi_cnt[c] + int'(hi_fire[c]);
      lo_cnt[c] <= cnt_clr ? 0 : lo_cnt[c] + int'(lo_fire[c]);
    end
    if (cnt_clr)
      all_seen <= 1'b0;
    else if (hi_fire == 8'hff && lo_fire == 8'hff)
      all_seen <= 1'b1;
  end

  task automatic conclude();
    if (err_total == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // ----------------
  // bus and frame helpers
  // ----------------
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string nm);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, reg_rdata, exp);
    @(posedge clk);
  endtask

  task automatic arm(input logic [7:0] b);
    i_sadl_host_model_arm.xfer(b);
    @(posedge clk);
  endtask

  task automatic dep(input logic [7:0] b);
    i_sadl_host_model_dep.xfer(b);
    @(posedge clk);
  endtask

  task automatic clr();
    cnt_clr <= 1'b1;
    @(posedge clk);
    cnt_clr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic settle();
    repeat (FIRE_C + 12) @(posedge clk);
  endtask

  // ----------------
  // scenarios
  // ----------------
  task automatic t_regs();
    rd(ADDR_STATUS, 32'h0000_0000, "status_rst");
    rd(ADDR_STATE, 32'h0000_0000, "state_rst");
    rd(ADDR_DIAG, 32'h0000_0000, "diag_rst");
    wr(ADDR_MASK, 32'hffff_ffff);
    rd(ADDR_MASK, 32'h0000_07ff, "mask_rw");
    wr(ADDR_MASK, 32'h0000_0000);
    wr(4'h2, 32'hffff_ffff);
    rd(4'h2, 32'h0000_0000, "unmapped");
    chk("drv_idle", {hi_fire, lo_fire}, 32'h0000_0000);
  endtask

  // short arming frame: refused as a command, flagged as frame error
  task automatic t_frame_err();
    i_sadl_host_model_arm.xfer(8'hf0, 4);
    @(posedge clk);
    rd(ADDR_STATUS, 32'h0000_0400, "frame_err");
    rd(ADDR_STATE, 32'h0000_0000, "no_arm_short");
    wr(ADDR_STATUS, 32'h0000_0400);
  endtask

  // arm first, deploy inside the timer; flags, daisy data and irq
  task automatic t_arm_first();
    clr();
    arm(8'h01);
    rd(ADDR_STATE, 32'h0000_0100, "timer_ch0");
    chk("no_early", hi_cnt[0], 32'h0000_0000);
    dep(8'h20);
    settle();
    chk("hi_len0", hi_cnt[0], FIRE_C);
    chk("lo_len0", lo_cnt[0], FIRE_C);
    rd(ADDR_STATUS, 32'h0000_0001, "ok_ch0");
    dep(8'h00);
    chk("ok_serial", i_sadl_host_model_dep.rx_q, 8'h01);
    arm(8'h00);
    chk("daisy", i_sadl_host_model_arm.rx_q, 8'h01);
    chk("irq_masked", irq, 1'b0);
    // irq trails status by a cycle, so look one edge later
    wr(ADDR_MASK, 32'h0000_0001);
    @(posedge clk);
    chk("irq_on", irq, 1'b1);
    wr(ADDR_STATUS, 32'h0000_0001);
    @(posedge clk);
    chk("irq_off", irq, 1'b0);
    rd(ADDR_STATUS, 32'h0000_0000, "w1c");
  endtask

  // deploy first then arm; lost ground on one channel only
  task automatic t_dep_first();
    clr();
    ground_ok <= 8'hf7;
    dep(8'h22);
    dep(8'h23);
    arm(8'h0c);
    settle();
    chk("fire2", hi_cnt[2], FIRE_C);
    chk("gnd3", hi_cnt[3] + lo_cnt[3], 32'h0000_0000);
    rd(ADDR_STATUS, 32'h0000_0004, "ok_ch2");
    wr(ADDR_STATUS, 32'h0000_00ff);
    ground_ok <= 8'hff;
  endtask

  // no permit, then a timer left to expire
  task automatic t_permit_expiry();
    clr();
    permit <= 1'b0;
    arm(8'h02);
    dep(8'h21);
    arm(8'h10);
    repeat (STR_C + 20) @(posedge clk);
    rd(ADDR_STATE, 32'h0000_0000, "unarmed");
    permit <= 1'b1;
    dep(8'h24);
    settle();
    chk("no_permit", hi_cnt[1] + lo_cnt[1], 32'h0000_0000);
    chk("expired", hi_cnt[4] + lo_cnt[4], 32'h0000_0000);
  endtask

  task automatic t_all();
    clr();
    for (int c = 0; c < 8; c++)
      dep(8'h20 | 8'(c));
    arm(8'hff);
    settle();
    chk("all_at_once", all_seen, 1'b1);
    for (int c = 0; c < 8; c++)
      chk("fire_len", hi_cnt[c], FIRE_C);
    rd(ADDR_STATUS, 32'h0000_00ff, "ok_all");
    wr(ADDR_STATUS, 32'h0000_00ff);
  endtask

  // four checks on channel 5, its ground lost
  task automatic t_diag();
    clr();
    permit    <= 1'b0;
    ground_ok <= 8'hdf;
    for (int k = 0; k < 4; k++)
    begin
      loop_volt <= (k == 0) ? 8'h20 : 8'h00;
      loop_curr <= (k == 0) ? 8'h00 : 8'h20;
      dep({3'(k + 2), 5'h05});
      repeat (DIAG_C + 12) @(posedge clk);
      rd(ADDR_DIAG, (k == 2) ? 32'h0 : 32'h20, "diag_fault");
      rd(ADDR_STATUS, (k == 2) ? 32'h100 : 32'h300, "diag_done");
      wr(ADDR_STATUS, 32'h0000_0300);
    end
    chk("diag_brief", lo_cnt[5] > 0 && lo_cnt[5] <= DIAG_C + 2, 1'b1);
    chk("diag_hi", hi_cnt[5] > 0 && hi_cnt[5] <= DIAG_C + 2, 1'b1);
    permit    <= 1'b1;
    ground_ok <= 8'hff;
    loop_curr <= 8'h00;
  endtask

  // reset pulsed mid-fire must wait for the end
  task automatic t_reset();
    int n;
    clr();
    arm(8'h40);
    dep(8'h26);
    n = 0;
    while (hi_fire[6] !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    settle();
    chk("fire_kept", hi_cnt[6], FIRE_C);
    rd(ADDR_STATUS, 32'h0000_0000, "rst_status");
    rd(ADDR_MASK, 32'h0000_0000, "rst_mask");
  endtask

  // main sequence
  initial
  begin
    reset_n   = 1'b0;
    permit    = 1'b1;
    ground_ok = 8'hff;
    loop_volt = 8'h00;
    loop_curr = 8'h00;
    reg_addr  = 4'h0;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    cnt_clr   = 1'b0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_frame_err();
    t_arm_first();
    t_dep_first();
    t_permit_expiry();
    t_all();
    t_diag();
    t_reset();
    conclude();
  end
endmodule // tb_top
